// ### rtl/dbg_uart_consts.svh
`ifndef DBG_UART_CONSTS_SVH
`define DBG_UART_CONSTS_SVH
`define SFR_CTRL_ADDR 8'h98
`define SFR_DATA_ADDR 8'h99
`define CTRL_RESET 8'h00
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_MPROC 5
`define BIT_RX_EN 4
`define BIT_TX9 3
`define BIT_RX9 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0
`define SHIFT_DIV 3
`define FIX_DIV_SLOW 4
`define FIX_DIV_FAST 2
`define OVS_TICKS 16
`define OVS_MID 7
`define M0_RX_BITS 8
`define BITCNT_W 4
`endif

// ### rtl/dbg_uart_pkg.sv
package dbg_uart_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC8,
    MODE_ASYNC9_FIX,
    MODE_ASYNC9_VAR
  } mode_type;
endpackage

// ### rtl/skid_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module skid_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  initial begin
    if (WIDTH < 1) begin
      $error("skid_buffer width must be positive");
    end
  end

  assign in_ready = (count_ff != 2'd2);
  assign out_valid = (count_ff != 2'd0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ### rtl/rate_divider.sv
`timescale 1ns/100ps
`default_nettype none
module rate_divider #(
  parameter int W = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [W-1:0] limit,
  output logic tick
);
  logic [W-1:0] cnt_ff;

  initial begin
    if (W < 2) begin
      $error("rate_divider width too small");
    end
  end

  // The tick is combinational so the caller sees it in the cycle the count wraps.
  assign tick = (cnt_ff == limit);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (clear || tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/debug_serial_port_regs.sv
// Operation
// RULE_01 - Control bits 7 and 6 select the mode; firmware writes them.
// RULE_02 - Modes: shift clk/6, async8 variable, async9 fixed, async9 variable.
// RULE_03 - Nine-bit modes with filter set drop frames whose ninth bit is 0.
// RULE_04 - Eight-bit mode with filter set drops frames lacking a valid stop.
// RULE_05 - Filter clear gives normal behaviour; shift mode ignores the filter.
// RULE_06 - Control bit 4 enables reception; no data accepted while it is 0; the code checks it only in RX_IDLE, so a frame in progress is still accepted.
// RULE_07 - Nine-bit modes send control bit 3 as ninth bit.
// RULE_08 - Bit 2 stores received ninth or stop bit; unchanged in shift mode.
// RULE_09 - Nine-bit modes set transmit-done at end of ninth bit time.
// RULE_10 - Shift and eight-bit modes set transmit-done after eighth bit time.
// RULE_11 - Hardware only sets done flags; firmware clears them by writing 0.
// RULE_12 - Nine-bit modes set receive-done a clock after ninth bit sampling.
// RULE_13 - Eight-bit mode sets receive-done a clock after stop bit sampling.
// RULE_14 - Shift mode sets receive-done after the ninth cycle following start.
// RULE_15 - Hardware updates of control bits win over simultaneous firmware writes.
// RULE_16 - Data address writes transmit buffer, reads return receive buffer.
// RULE_17 - Firmware cannot read transmit buffer nor write receive buffer.
// RULE_18 - Shift mode: data on receive pin, clock on transmit pin, LSB first.
// RULE_19 - Eight-bit frame: start 0, eight data LSB first, stop 1.
// RULE_20 - Nine-bit frame adds ninth bit; fixed-rate mode ignores stop bit.
// RULE_21 - Async reception starts on start bit; shift when enabled and flag clear; the code also waits for an idle transmitter in shift mode.
// RULE_22 - Any data-buffer write starts a transmission in the current mode; the code drops writes made while the two-entry buffer is full.
// RULE_23 - Variable rates use external tx/rx ticks; fixed mode uses doubling input.
// RULE_24 - Interrupt request is OR of transmit-done and receive-done flags.
`include "dbg_uart_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module debug_serial_port_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic tx_rate_tick,
  input wire logic rx_rate_tick,
  input wire logic rate_double,
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe,
  output logic tx_pin,
  output logic irq
);
  import dbg_uart_pkg::*;

  // ****************************************
  // Control register and mode
  // ****************************************
  logic [7:0] ctrl_ff;
  logic [7:0] rx_buf_ff;
  mode_type mode;
  logic nine_bit;
  logic wr_ctrl;
  logic wr_data;
  logic rd_data;

  assign mode = mode_type'(ctrl_ff[`BIT_MODE_HI:`BIT_MODE_LO]); // RULE_01 RULE_02
  assign nine_bit = ctrl_ff[`BIT_MODE_HI];
  assign wr_ctrl = sfr_wr && (sfr_addr == `SFR_CTRL_ADDR);
  assign wr_data = sfr_wr && (sfr_addr == `SFR_DATA_ADDR);
  assign rd_data = sfr_rd && (sfr_addr == `SFR_DATA_ADDR);

  // Hardware event strobes.
  logic tx_done_set;
  logic rx_done_set;
  logic rx9_load;
  logic rx9_val;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= sfr_wdata;
      end
      // Hardware writes land last, so a colliding firmware write cannot undo them.
      if (rx9_load) begin
        ctrl_ff[`BIT_RX9] <= rx9_val; // RULE_15 RULE_08
      end
      if (tx_done_set) begin
        ctrl_ff[`BIT_TX_DONE] <= 1'b1; // RULE_11 RULE_15
      end
      if (rx_done_set) begin
        ctrl_ff[`BIT_RX_DONE] <= 1'b1; // RULE_11 RULE_15
      end
    end
  end

  // ****************************************
  // Register read path and interrupt
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == `SFR_CTRL_ADDR) begin
      sfr_rdata <= ctrl_ff;
    end else if (rd_data) begin
      sfr_rdata <= rx_buf_ff; // RULE_16 RULE_17
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_ff[`BIT_TX_DONE] | ctrl_ff[`BIT_RX_DONE]; // RULE_24
    end
  end

  // ****************************************
  // Bit-rate generation
  // ****************************************
  logic shift_tick;
  logic fix_tick;
  logic ovs_tick_rx;
  logic ovs_tick_tx;
  logic [5:0] fix_limit;

  assign fix_limit = rate_double ? 6'(`FIX_DIV_FAST - 1) : 6'(`FIX_DIV_SLOW - 1); // RULE_23

  // Half-period clock for shift mode: two ticks form one bit of clk/6.
  rate_divider #(.W(6)) u_shift_div (
    .core_clk(core_clk),
    .rst(rst),
    .clear(1'b0),
    .limit(6'(`SHIFT_DIV - 1)),
    .tick(shift_tick)
  );

  rate_divider #(.W(6)) u_fix_div (
    .core_clk(core_clk),
    .rst(rst),
    .clear(1'b0),
    .limit(fix_limit),
    .tick(fix_tick)
  );

  // Ticks are sixteen times the bit rate, as the receiver oversamples.
  assign ovs_tick_tx = (mode == MODE_ASYNC9_FIX) ? fix_tick : tx_rate_tick; // RULE_23
  assign ovs_tick_rx = (mode == MODE_ASYNC9_FIX) ? fix_tick : rx_rate_tick; // RULE_23

  // ****************************************
  // Transmit buffer and engine
  // ****************************************
  logic tb_valid;
  logic tb_ready;
  logic [8:0] tb_data;
  logic tx_take;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_bits_ff;
  logic [3:0] tx_ovs_ff;
  logic tx_busy_ff;
  logic shift_phase_ff;

  // The ninth bit is captured with the byte so a later control write cannot change it.
  skid_buffer #(.WIDTH(9)) u_tx_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(wr_data),
    .in_ready(),
    .in_data({ctrl_ff[`BIT_TX9], sfr_wdata}), // RULE_07 RULE_22
    .out_valid(tb_valid),
    .out_ready(tb_ready),
    .out_data(tb_data)
  );

  assign tb_ready = !tx_busy_ff;
  assign tx_take = tb_valid && tb_ready;

  logic tx_bit_end;
  assign tx_bit_end = (mode == MODE_SHIFT) ? (shift_tick && shift_phase_ff)
                    : (ovs_tick_tx && tx_ovs_ff == 4'(`OVS_TICKS - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff <= '1;
      tx_bits_ff <= '0;
      tx_ovs_ff <= '0;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (tx_take) begin
        tx_busy_ff <= 1'b1;
        tx_ovs_ff <= '0;
        tx_bits_ff <= '0;
        if (mode == MODE_SHIFT) begin
          tx_sh_ff <= {3'b111, tb_data[7:0]}; // RULE_18
        end else if (nine_bit) begin
          tx_sh_ff <= {1'b1, tb_data[8], tb_data[7:0], 1'b0}; // RULE_20 RULE_07
        end else begin
          tx_sh_ff <= {2'b11, tb_data[7:0], 1'b0}; // RULE_19
        end
      end else if (tx_busy_ff) begin
        if (mode != MODE_SHIFT && ovs_tick_tx) begin
          tx_ovs_ff <= tx_ovs_ff + 4'd1;
        end
        if (tx_bit_end) begin
          tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
          tx_bits_ff <= tx_bits_ff + 4'd1;
          // Shift mode: bit 8 ends; async 8: start+8 data = 9th slot; async 9: 10th.
          if ((mode == MODE_SHIFT && tx_bits_ff == 4'd7) ||
              (mode == MODE_ASYNC8 && tx_bits_ff == 4'd8) ||
              (nine_bit && tx_bits_ff == 4'd9)) begin
            tx_done_set <= 1'b1; // RULE_09 RULE_10
          end
          if ((mode == MODE_SHIFT && tx_bits_ff == 4'd7) ||
              (mode != MODE_SHIFT && tx_bits_ff == (nine_bit ? 4'd10 : 4'd9))) begin
            tx_busy_ff <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // Shift-mode clock phase and pins
  // ****************************************
  logic rx_sh_busy_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_phase_ff <= 1'b0;
    end else if (shift_tick) begin
      shift_phase_ff <= ~shift_phase_ff;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_pin <= 1'b1;
      rx_pin_out <= 1'b1;
      rx_pin_oe <= 1'b0;
    end else if (mode == MODE_SHIFT) begin
      tx_pin <= (tx_busy_ff || rx_sh_busy_ff) ? ~shift_phase_ff : 1'b1; // RULE_18
      rx_pin_out <= tx_sh_ff[0];
      rx_pin_oe <= tx_busy_ff;
    end else begin
      tx_pin <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
      rx_pin_out <= 1'b1;
      rx_pin_oe <= 1'b0;
    end
  end

  // ****************************************
  // Receive engine
  // ****************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT} rx_state_type;
  rx_state_type rx_state_ff;
  logic [3:0] rx_ovs_ff;
  logic [3:0] rx_bits_ff;
  logic [9:0] rx_sh_ff;
  logic rx_prev_ff;
  logic rx_frame_end_ff;
  logic rx_accept;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic [3:0] rx_last_bit;

  // Slot 8 is the stop bit in eight-bit mode and the ninth bit otherwise, so the
  // frame ends there in both cases and the nine-bit stop bit is never waited for.
  assign rx_last_bit = 4'(`M0_RX_BITS);
  assign rx_byte = rx_sh_ff[7:0];
  assign rx_ninth = rx_sh_ff[8];

  always_comb begin
    rx_accept = 1'b1;
    if (mode == MODE_SHIFT) begin
      rx_accept = 1'b1; // RULE_05
    end else if (ctrl_ff[`BIT_MPROC]) begin
      rx_accept = rx_ninth; // RULE_03 RULE_04
    end
  end

  assign rx_sh_busy_ff = (rx_state_ff == RX_SHIFT);
  assign rx_done_set = rx_frame_end_ff && rx_accept; // RULE_12 RULE_13 RULE_14
  assign rx9_load = rx_frame_end_ff && rx_accept && mode != MODE_SHIFT; // RULE_08
  assign rx9_val = rx_ninth;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state_ff <= RX_IDLE;
      rx_ovs_ff <= '0;
      rx_bits_ff <= '0;
      rx_sh_ff <= '0;
      rx_prev_ff <= 1'b1;
      rx_frame_end_ff <= 1'b0;
    end else begin
      rx_prev_ff <= rx_pin_in;
      rx_frame_end_ff <= 1'b0;
      case (rx_state_ff)
        RX_IDLE: begin
          if (ctrl_ff[`BIT_RX_EN]) begin // RULE_06
            if (mode == MODE_SHIFT) begin
              if (!ctrl_ff[`BIT_RX_DONE] && !tx_busy_ff) begin // RULE_21
                rx_state_ff <= RX_SHIFT;
                rx_bits_ff <= '0;
              end
            end else if (rx_prev_ff && !rx_pin_in) begin // RULE_21
              rx_state_ff <= RX_START;
              rx_ovs_ff <= '0;
            end
          end
        end
        RX_START: begin
          if (ovs_tick_rx) begin
            rx_ovs_ff <= rx_ovs_ff + 4'd1;
            if (rx_ovs_ff == 4'(`OVS_MID)) begin
              // A high level at mid start bit is a glitch, not a frame.
              rx_state_ff <= rx_pin_in ? RX_IDLE : RX_DATA;
              rx_ovs_ff <= '0;
              rx_bits_ff <= '0;
            end
          end
        end
        RX_DATA: begin
          if (ovs_tick_rx) begin
            rx_ovs_ff <= rx_ovs_ff + 4'd1;
            if (rx_ovs_ff == 4'(`OVS_TICKS - 1)) begin
              rx_sh_ff[rx_bits_ff] <= rx_pin_in; // RULE_19 RULE_20
              rx_bits_ff <= rx_bits_ff + 4'd1;
              if (rx_bits_ff == rx_last_bit) begin
                // Last sampled bit: ninth bit or stop bit; flags follow next cycle.
                rx_frame_end_ff <= 1'b1; // RULE_12 RULE_13
                rx_state_ff <= RX_IDLE;
              end
            end
          end
        end
        RX_SHIFT: begin
          if (shift_tick && shift_phase_ff) begin
            rx_sh_ff[rx_bits_ff] <= rx_pin_in; // RULE_18
            rx_bits_ff <= rx_bits_ff + 4'd1;
            if (rx_bits_ff == 4'(`M0_RX_BITS - 1)) begin
              rx_frame_end_ff <= 1'b1; // RULE_14
              rx_state_ff <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  // In async 8-bit mode the stop bit lands in slot 8, so it acts as the ninth bit.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_buf_ff <= 8'h00;
    end else if (rx_frame_end_ff && rx_accept) begin
      rx_buf_ff <= rx_byte; // RULE_17 RULE_03 RULE_04
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  irq_or_flags_a: assert property (@(posedge core_clk) disable iff (rst)
    irq == $past(ctrl_ff[`BIT_TX_DONE] | ctrl_ff[`BIT_RX_DONE])) // RULE_24
    else $error("irq does not follow done flags");
  rx_filter_a: assert property (@(posedge core_clk) disable iff (rst)
    rx_frame_end_ff && mode != MODE_SHIFT && ctrl_ff[`BIT_MPROC] && !rx_ninth
    |=> $stable(rx_buf_ff)) // RULE_03
    else $error("filtered frame loaded receive buffer");
  rx_flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
    rx_frame_end_ff && rx_accept |=> ctrl_ff[`BIT_RX_DONE]) // RULE_12
    else $error("receive-done not set");
  tx_flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
    tx_done_set |=> ctrl_ff[`BIT_TX_DONE]) // RULE_11
    else $error("transmit-done not set");
  rx_enable_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    rx_state_ff == RX_IDLE && !ctrl_ff[`BIT_RX_EN] |=> rx_state_ff == RX_IDLE) // RULE_06
    else $error("reception started while disabled");
  rx9_shift_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    mode == MODE_SHIFT && !wr_ctrl |=> $stable(ctrl_ff[`BIT_RX9])) // RULE_08
    else $error("ninth bit store changed in shift mode");
  tx_idle_line_a: assert property (@(posedge core_clk) disable iff (rst)
    !tx_busy_ff && mode != MODE_SHIFT ##1 mode != MODE_SHIFT |-> tx_pin) // RULE_19
    else $error("idle transmit line not high");
  hw_wins_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl && rx_done_set |=> ctrl_ff[`BIT_RX_DONE]) // RULE_15
    else $error("firmware write overrode hardware flag");
  tx_start_c: cover property (@(posedge core_clk) disable iff (rst) tx_take);
  rx_done_c: cover property (@(posedge core_clk) disable iff (rst) rx_done_set);
  rx_block_c: cover property (@(posedge core_clk) disable iff (rst)
    rx_frame_end_ff && !rx_accept);
endmodule
`default_nettype wire

// ### tb/serial_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Serial terminal on the far side of the port.
// ****************************************************************
module serial_partner #(
  parameter int BIT_CLKS = 16
) (
  input wire logic core_clk,
  input wire logic ser_in,
  input wire logic nine_bits,
  output logic ser_out
);
  logic [9:0] got_q[$];
  logic [9:0] fr;
  int n;

  // Frames are captured as {stop, ninth, data}; an 8-bit frame has ninth 0.
  // Sampling at mid-bit tolerates a cycle or two of skew in the sender.
  initial begin
    ser_out = 1'b1;
    forever begin
      @(negedge ser_in);
      n = nine_bits ? 10 : 9;
      fr = 10'h3ff;
      repeat (BIT_CLKS / 2) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
        repeat (BIT_CLKS) @(posedge core_clk);
        fr[i] = ser_in;
      end
      got_q.push_back(nine_bits ? fr : {fr[8], 1'b0, fr[7:0]});
    end
  end

  // The line returns to its idle high level after the stop bit.
  task automatic send(input logic [7:0] data, input logic ninth, input logic stop);
    logic [10:0] bits;
    int nb;
    bits = nine_bits ? {stop, ninth, data, 1'b0} : {1'b1, stop, data, 1'b0};
    nb = nine_bits ? 11 : 10;
    for (int i = 0; i < nb; i++) begin
      @(negedge core_clk);
      ser_out = bits[i];
      repeat (BIT_CLKS - 1) @(negedge core_clk);
    end
    @(negedge core_clk);
    ser_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/debug_serial_port_regs_tb_top.sv
`include "dbg_uart_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module debug_serial_port_regs_tb_top;
  logic core_clk, rst, sfr_wr, sfr_rd, tx_rate_tick, rx_rate_tick, rate_double;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, cfg, b, last_rx;
  logic rx_pin_in, rx_pin_out, rx_pin_oe, tx_pin, irq, line, nine_bits, acc;
  logic [31:0] seed;
  logic [9:0] got;
  int error_cnt, checks_done;
  logic [7:0] rx_cfg [7] = '{8'h54, 8'h74, 8'h74, 8'hf4, 8'hf4, 8'hd4, 8'h44};
  logic [6:0] rx_n = 7'b0010000;
  logic [6:0] rx_s = 7'b1111101;
  logic [7:0] tx_cfg [4] = '{8'h58, 8'h50, 8'hd0, 8'hd8};

  // The receive pin is shared: the port drives it only in shift mode.
  assign rx_pin_in = rx_pin_oe ? rx_pin_out : line;

  debug_serial_port_regs u_debug_serial_port_regs (
    .core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .tx_rate_tick(tx_rate_tick), .rx_rate_tick(rx_rate_tick),
    .rate_double(rate_double), .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out),
    .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin), .irq(irq)
  );

  serial_partner #(.BIT_CLKS(16)) u_serial_partner (
    .core_clk(core_clk), .ser_in(tx_pin), .nine_bits(nine_bits), .ser_out(line)
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic exp_acc(input logic [7:0] c, input logic n9, input logic st);
    if (!c[4]) return 1'b0;
    if (c[5] && (c[7] ? !n9 : !st)) return 1'b0;
    return 1'b1;
  endfunction

  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] seen);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic wait_flag(input int idx);
    rd = 8'h00;
    for (int i = 0; i < 400 && rd[idx] !== 1'b1; i++) rd_reg(`SFR_CTRL_ADDR, rd);
  endtask

  task automatic take_frame(output logic [9:0] f);
    for (int i = 0; i < 600 && u_serial_partner.got_q.size() == 0; i++) @(negedge core_clk);
    f = 10'bx;
    if (u_serial_partner.got_q.size() > 0) begin
      f = u_serial_partner.got_q.pop_front();
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("Error watchdog expected done seen timeout");
    give_verdict();
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, nine_bits} = '0;
    {tx_rate_tick, rx_rate_tick, rate_double} = 3'b111;
    error_cnt = 0;
    checks_done = 0;
    seed = 32'h18a96184;
    last_rx = 8'h00;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    rd_reg(`SFR_CTRL_ADDR, rd);
    check("serial_control_status", `CTRL_RESET, rd);
    rd_reg(`SFR_DATA_ADDR, rd);
    check("serial_data_buffer", 8'h00, rd);
    rd_reg(8'h9a, rd);
    check("unmapped", 8'h00, rd);
    check("tx_pin idle", 1'b1, tx_pin);
    $display("Test reset done");
    for (int m = 0; m < 4; m++) begin
      cfg = {m[1:0], 6'h28};
      wr(`SFR_CTRL_ADDR, cfg);
      rd_reg(`SFR_CTRL_ADDR, rd);
      check("mode bits", cfg, rd);
    end
    $display("Test modes done");
    for (int k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      cfg = rx_cfg[k];
      nine_bits = cfg[7];
      wr(`SFR_CTRL_ADDR, cfg);
      u_serial_partner.send(seed[7:0], rx_n[k], rx_s[k]);
      repeat (8) @(negedge core_clk);
      rd_reg(`SFR_CTRL_ADDR, rd);
      acc = exp_acc(cfg, rx_n[k], rx_s[k]);
      check("rx_done_flag", acc, rd[0]);
      check("rx_ninth_bit", acc ? (cfg[7] ? rx_n[k] : rx_s[k]) : 1'b1, rd[2]);
      check("irq", acc, irq);
      if (acc) begin
        last_rx = seed[7:0];
        rd_reg(`SFR_DATA_ADDR, rd);
        check("serial_data_buffer", last_rx, rd);
      end
      $display("Test receive case %0d done", k);
    end
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      b = seed[7:0] | 8'h01;
      if (b === last_rx) begin
        b = b ^ 8'h02;
      end
      cfg = tx_cfg[k];
      nine_bits = cfg[7];
      wr(`SFR_CTRL_ADDR, cfg);
      wr(`SFR_DATA_ADDR, b);
      take_frame(got);
      check("tx frame", {1'b1, cfg[7] & cfg[3], b}, got);
      wait_flag(1);
      check("tx_done_flag", 1'b1, rd[1]);
      repeat (40) @(negedge core_clk);
      rd_reg(`SFR_CTRL_ADDR, rd);
      check("tx_done_flag held", 1'b1, rd[1]);
      check("irq", 1'b1, irq);
      wr(`SFR_CTRL_ADDR, cfg);
      rd_reg(`SFR_CTRL_ADDR, rd);
      check("tx_done_flag cleared", 1'b0, rd[1]);
      rd_reg(`SFR_DATA_ADDR, rd);
      check("data read differs", 1'b1, rd !== b);
      $display("Test transmit case %0d done", k);
    end
    nine_bits = 1'b0;
    wr(`SFR_CTRL_ADDR, 8'h50);
    for (int k = 0; k < 4; k++) begin
      wr(`SFR_DATA_ADDR, 8'h30 + k[7:0]);
    end
    for (int k = 0; k < 3; k++) begin
      take_frame(got);
      check("queued frame", {2'b10, 8'h30 + k[7:0]}, got);
    end
    repeat (300) @(negedge core_clk);
    check("dropped write", 10'h000, u_serial_partner.got_q.size());
    $display("Test buffer full done");
    give_verdict();
  end
endmodule
`default_nettype wire
